// File: hdl/tcs_timer.sv
`timescale 1ns/1ps
`include "tcs_cfg.svh"
// Contract
// - general registers are 16-bit compare or capture
// - four registers on 0,3; two elsewhere
// - C buffers A, D buffers B
// - general registers accessed as whole words
// - run register bits start/stop channels, reset 0
// - stopping keeps current compare output level
// - control write while stopped drives initial level
// - sync select bits group channels, reset 0
// - counter write presets all grouped counters
// - sync clear needs sync bit and source
// - up-count free-run, periodic, external events
// - counters reset to zero, word access
// - wrap sets overflow flag, keeps counting
module tcs_timer import tcs_pkg::*; #(
	parameter int NCH = 6
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [5:0] i_pin,
	input wire logic [5:0] i_ext_clk,
	output logic [15:0] o_rdata,
	output logic o_irq,
	output logic [5:0] o_pin_o,
	output logic [5:0] o_pin_oe
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// true for the channels that own registers C and D
	function automatic logic has_buf(input int c);
		has_buf = (c == `TCS_BUF_CH0) || (c == `TCS_BUF_CH1);
	endfunction

	// true when the address falls in channel c's window
	function automatic logic chan_sel(input logic [7:0] a, input int c);
		chan_sel = (a[7:4] == 4'(4 + c));
	endfunction

	// new pin level from a compare action
	function automatic logic pin_act(input tcs_act_t a, input logic p);
		case (a)
			TCS_ACT_LOW: pin_act = 1'b0;
			TCS_ACT_HIGH: pin_act = 1'b1;
			TCS_ACT_TOGGLE: pin_act = ~p;
			default: pin_act = p;
		endcase
	endfunction

	// ----------------------------------------
	// input synchronisers (pins are asynchronous)
	// ----------------------------------------
	logic [5:0] pin_s1_q; // first stage, read only by second
	logic [5:0] pin_s2_q;
	logic [5:0] ext_s1_q;
	logic [5:0] ext_s2_q;
	// sync stages run apart from the state struct to keep stage one private
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pin_s1_q <= 6'h00;
			pin_s2_q <= 6'h00;
			ext_s1_q <= 6'h00;
			ext_s2_q <= 6'h00;
		end else begin
			pin_s1_q <= i_pin;
			pin_s2_q <= pin_s1_q;
			ext_s1_q <= i_ext_clk;
			ext_s2_q <= ext_s1_q;
		end
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	tcs_state_t st_q; // registered state apart from the input synchronisers
	tcs_state_t st_d; // next state
	tcs_bus_t bus; // bundled bus request
	logic [5:0] clr_ev; // per-channel clearing event this cycle
	logic [5:0] pre_hit; // per-channel counter write seen
	logic sync_clr; // any grouped channel clearing on its own source
	logic sync_pre; // write hit a grouped counter
	logic [15:0] pre_val; // preset value

	assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		logic [3:0] sub;
		logic [2:0] idx;
		logic hit_a;
		logic hit_b;
		logic edge_a;
		logic edge_b;
		logic tick;
		logic [15:0] nxt;
		logic [17:0] set_v;
		set_v = 18'h00000;
		sub = 4'h0;
		idx = 3'h0;
		hit_a = 1'b0;
		hit_b = 1'b0;
		edge_a = 1'b0;
		edge_b = 1'b0;
		tick = 1'b0;
		nxt = 16'h0000;
		st_d = st_q;
		clr_ev = 6'h00;
		pre_hit = 6'h00;
		sync_clr = 1'b0;
		sync_pre = 1'b0;
		pre_val = bus.wdata;

		// pass 1: find counter writes and own-source clears
		for (int c = 0; c < NCH; c++) begin
			if (bus.wr && bus.addr == (`TCS_OFF_CH_BASE + 8'(c << `TCS_CH_STRIDE_SH) + 8'(`TCS_SUB_CNT))) begin
				pre_hit[c] = 1'b1;
			end
			hit_a = st_q.run[c] && !st_q.ch[c].ctl.cap_a && (st_q.ch[c].cnt == st_q.ch[c].gra);
			hit_b = st_q.run[c] && !st_q.ch[c].ctl.cap_b && (st_q.ch[c].cnt == st_q.ch[c].grb);
			// capture edges: both edges on A, rising on B
			edge_a = st_q.run[c] && st_q.ch[c].ctl.cap_a && (st_q.ch[c].ev_q[1] != pin_s2_q[c]);
			edge_b = st_q.run[c] && st_q.ch[c].ctl.cap_b && pin_s2_q[c] && !st_q.ch[c].ev_q[1];
			if ((st_q.ch[c].ctl.clr == TCS_CLR_GRA && (hit_a || edge_a))
				|| (st_q.ch[c].ctl.clr == TCS_CLR_GRB && (hit_b || edge_b))) begin
				clr_ev[c] = 1'b1;
			end
		end
		// a lone grouped channel acts as independent
		sync_clr = |(clr_ev & st_q.sync) && ($countones(st_q.sync) > 1);
		sync_pre = |(pre_hit & st_q.sync) && ($countones(st_q.sync) > 1);

		// pass 2: per-channel update
		for (int c = 0; c < NCH; c++) begin
			hit_a = st_q.run[c] && !st_q.ch[c].ctl.cap_a && (st_q.ch[c].cnt == st_q.ch[c].gra);
			hit_b = st_q.run[c] && !st_q.ch[c].ctl.cap_b && (st_q.ch[c].cnt == st_q.ch[c].grb);
			edge_a = st_q.run[c] && st_q.ch[c].ctl.cap_a && (st_q.ch[c].ev_q[1] != pin_s2_q[c]);
			edge_b = st_q.run[c] && st_q.ch[c].ctl.cap_b && pin_s2_q[c] && !st_q.ch[c].ev_q[1];
			st_d.ch[c].ev_q = {st_q.ch[c].ev_q[1], pin_s2_q[c], ext_s2_q[c]};
			// external mode counts rising edges, else every clock
			tick = st_q.ch[c].ctl.ext_cnt ? (ext_s2_q[c] && !st_q.ch[c].ev_q[0]) : 1'b1;
			nxt = st_q.ch[c].cnt + 16'h0001;
			if (st_q.run[c] && tick) begin
				st_d.ch[c].cnt = nxt;
				if (st_q.ch[c].cnt == 16'hFFFF) begin
					set_v[c] = 1'b1;
				end
			end
			// clears override counting
			if (clr_ev[c] || (sync_clr && st_q.sync[c] && st_q.ch[c].ctl.clr == TCS_CLR_SYNC)) begin
				st_d.ch[c].cnt = `TCS_RST_CNT;
			end
			// compare outputs and buffer transfers
			if (hit_a) begin
				set_v[6 + 2 * c] = 1'b1;
				st_d.ch[c].pin = pin_act(st_q.ch[c].ctl.act_a, st_q.ch[c].pin);
				if (has_buf(c) && st_q.ch[c].ctl.buf_a) begin
					st_d.ch[c].gra = st_q.ch[c].grc;
				end
			end
			if (hit_b) begin
				set_v[7 + 2 * c] = 1'b1;
				st_d.ch[c].pin = pin_act(st_q.ch[c].ctl.act_b, hit_a ? st_d.ch[c].pin : st_q.ch[c].pin);
				if (has_buf(c) && st_q.ch[c].ctl.buf_b) begin
					st_d.ch[c].grb = st_q.ch[c].grd;
				end
			end
			// capture
			if (edge_a) begin
				set_v[6 + 2 * c] = 1'b1;
				st_d.ch[c].gra = st_q.ch[c].cnt;
				if (has_buf(c) && st_q.ch[c].ctl.buf_a) begin
					st_d.ch[c].grc = st_q.ch[c].gra;
				end
			end
			if (edge_b) begin
				set_v[7 + 2 * c] = 1'b1;
				st_d.ch[c].grb = st_q.ch[c].cnt;
				if (has_buf(c) && st_q.ch[c].ctl.buf_b) begin
					st_d.ch[c].grd = st_q.ch[c].grb;
				end
			end
			// software preset wins, and spreads to the group
			if (pre_hit[c] || (sync_pre && st_q.sync[c])) begin
				st_d.ch[c].cnt = pre_val;
			end
		end

		// register writes (whole 16-bit words only)
		if (bus.wr) begin
			if (bus.addr == `TCS_OFF_RUN) begin
				st_d.run = bus.wdata[5:0];
			end
			if (bus.addr == `TCS_OFF_SYNC) begin
				st_d.sync = bus.wdata[5:0];
			end
			for (int c = 0; c < NCH; c++) begin
				sub = bus.addr[3:0];
				idx = 3'(c);
				if (chan_sel(bus.addr, c)) begin
					case (sub)
						`TCS_SUB_CTRL: begin
							st_d.ch[c].ctl = tcs_ctl_t'(bus.wdata[13:0]);
							if (!st_q.run[c]) begin
								st_d.ch[c].pin = bus.wdata[`TCS_CTL_INIT_BIT];
							end
						end
						`TCS_SUB_GRA: st_d.ch[c].gra = bus.wdata;
						`TCS_SUB_GRB: st_d.ch[c].grb = bus.wdata;
						default: ;
					endcase
				end
				if (has_buf(c) && bus.addr == (`TCS_OFF_BUF_BASE + 8'(c << `TCS_CH_STRIDE_SH) + 8'(`TCS_BSUB_GRC))) begin
					st_d.ch[c].grc = bus.wdata;
				end
				if (has_buf(c) && bus.addr == (`TCS_OFF_BUF_BASE + 8'(c << `TCS_CH_STRIDE_SH) + 8'(`TCS_BSUB_GRD))) begin
					st_d.ch[c].grd = bus.wdata;
				end
			end
		end

		// write-one-to-clear status, a same-cycle event always wins
		st_d.stat = st_q.stat | set_v;
		if (bus.wr && bus.addr == `TCS_OFF_IRQ_STAT) begin
			st_d.stat = (st_q.stat & ~{2'b00, bus.wdata}) | set_v;
		end
		// status holds six overflows and twelve A/B match flags; mask bits 17:16 stay zero, only bits 15:0 are writable
		if (bus.wr && bus.addr == `TCS_OFF_IRQ_MASK) begin
			st_d.mask = {2'b00, bus.wdata};
		end

		// read mux, data valid in the next cycle only
		st_d.rdata = 16'h0000;
		if (bus.rd) begin
			case (bus.addr)
				`TCS_OFF_RUN: st_d.rdata = {10'h000, st_q.run};
				`TCS_OFF_SYNC: st_d.rdata = {10'h000, st_q.sync};
				`TCS_OFF_IRQ_STAT: st_d.rdata = st_q.stat[15:0];
				`TCS_OFF_IRQ_MASK: st_d.rdata = st_q.mask[15:0];
				default: begin
					for (int c = 0; c < NCH; c++) begin
						if (chan_sel(bus.addr, c)) begin
							case (bus.addr[3:0])
								`TCS_SUB_CNT: st_d.rdata = st_q.ch[c].cnt;
								`TCS_SUB_CTRL: st_d.rdata = {2'b00, 14'(st_q.ch[c].ctl)};
								`TCS_SUB_GRA: st_d.rdata = st_q.ch[c].gra;
								`TCS_SUB_GRB: st_d.rdata = st_q.ch[c].grb;
								default: st_d.rdata = 16'h0000;
							endcase
						end
						if (has_buf(c) && bus.addr == (`TCS_OFF_BUF_BASE + 8'(c << `TCS_CH_STRIDE_SH))) begin
							st_d.rdata = st_q.ch[c].grc;
						end
						if (has_buf(c) && bus.addr == (`TCS_OFF_BUF_BASE + 8'(c << `TCS_CH_STRIDE_SH) + 8'h04)) begin
							st_d.rdata = st_q.ch[c].grd;
						end
					end
				end
			endcase
		end

		// registered outputs; a stopped channel's pin level moves only on a control write
		for (int c = 0; c < NCH; c++) begin
			st_d.pin_o[c] = st_d.ch[c].pin;
			st_d.pin_oe[c] = st_d.ch[c].ctl.pin_out;
		end
		st_d.irq = |(st_d.stat[15:0] & st_d.mask[15:0]);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_q <= '0;
			for (int c = 0; c < NCH; c++) begin
				st_q.ch[c].gra <= `TCS_RST_GR;
				st_q.ch[c].grb <= `TCS_RST_GR;
				st_q.ch[c].grc <= `TCS_RST_GR;
				st_q.ch[c].grd <= `TCS_RST_GR;
			end
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata = st_q.rdata;
	assign o_irq = st_q.irq;
	assign o_pin_o = st_q.pin_o;
	assign o_pin_oe = st_q.pin_oe;
endmodule

// File: hdl/tcs_cfg.svh
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// ----------------------------------------
// register map (word index == byte offset / 4)
// ----------------------------------------
`define TCS_ADDR_W 8
`define TCS_OFF_RUN 8'h00
`define TCS_OFF_SYNC 8'h04
`define TCS_OFF_IRQ_STAT 8'h08
`define TCS_OFF_IRQ_MASK 8'h0C
`define TCS_OFF_CH_BASE 8'h40
`define TCS_CH_STRIDE_SH 4
// per-channel sub-offsets, within a 16-byte window
`define TCS_SUB_CNT 4'h0
`define TCS_SUB_CTRL 4'h4
`define TCS_SUB_GRA 4'h8
`define TCS_SUB_GRB 4'hC
// registers C and D of channels 0 and 3 live in a second window
`define TCS_OFF_BUF_BASE 8'hC0
`define TCS_BSUB_GRC 4'h0
`define TCS_BSUB_GRD 4'h4
// ----------------------------------------
// per-channel control word fields
// ----------------------------------------
`define TCS_CTL_CLR_LSB 0
`define TCS_CTL_EXT_BIT 3
`define TCS_CTL_BUFA_BIT 4
`define TCS_CTL_BUFB_BIT 5
`define TCS_CTL_CAPA_BIT 6
`define TCS_CTL_CAPB_BIT 7
`define TCS_CTL_OUT_BIT 8
`define TCS_CTL_INIT_BIT 9
`define TCS_CTL_ACTA_LSB 10
`define TCS_CTL_ACTB_LSB 12
// ----------------------------------------
// reset values
// ----------------------------------------
`define TCS_RST_RUN 6'h00
`define TCS_RST_SYNC 6'h00
`define TCS_RST_CNT 16'h0000
`define TCS_RST_GR 16'hFFFF
`define TCS_BUF_CH0 0
`define TCS_BUF_CH1 3
`endif

// File: hdl/tcs_pkg.sv
package tcs_pkg;
	// counter clearing source
	typedef enum logic [2:0] {
		TCS_CLR_NONE = 3'h0,
		TCS_CLR_GRA = 3'h1,
		TCS_CLR_GRB = 3'h2,
		TCS_CLR_SYNC = 3'h3
	} tcs_clr_t;
	// compare-match pin action
	typedef enum logic [1:0] {
		TCS_ACT_KEEP = 2'h0,
		TCS_ACT_LOW = 2'h1,
		TCS_ACT_HIGH = 2'h2,
		TCS_ACT_TOGGLE = 2'h3
	} tcs_act_t;
	// per-channel control word
	typedef struct packed {
		tcs_act_t act_b;
		tcs_act_t act_a;
		logic init_lvl;
		logic pin_out;
		logic cap_b;
		logic cap_a;
		logic buf_b;
		logic buf_a;
		logic ext_cnt;
		tcs_clr_t clr;
	} tcs_ctl_t;
	// register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} tcs_bus_t;
	// one channel's state
	typedef struct packed {
		logic [15:0] cnt;
		logic [15:0] gra;
		logic [15:0] grb;
		logic [15:0] grc;
		logic [15:0] grd;
		tcs_ctl_t ctl;
		logic pin;
		logic [2:0] ev_q;
	} tcs_ch_t;
	// whole module state
	typedef struct packed {
		tcs_ch_t [5:0] ch;
		logic [5:0] run;
		logic [5:0] sync;
		logic [17:0] stat;
		logic [17:0] mask;
		logic [15:0] rdata;
		logic irq;
		logic [5:0] pin_o;
		logic [5:0] pin_oe;
	} tcs_state_t;
endpackage

// File: testbench/tcs_timer_properties.sv
`timescale 1ns/1ps
module tcs_chk #(
	parameter int NCH = 6
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic [5:0] o_pin_o,
	input wire logic [5:0] o_pin_oe
);
	// ----------
	// shadows
	// ----------
	logic [5:0] run_q; // run bits as written
	logic [5:0] sync_q; // group bits as written
	logic [3:0] mode0_q; // ch0 clear source and ext count
	// follows writes only, never the design
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			run_q <= 6'h00;
			sync_q <= 6'h00;
			mode0_q <= 4'h0;
		end else if (i_wr) begin
			if (i_addr == 8'h00) begin
				run_q <= i_wdata[5:0];
			end
			if (i_addr == 8'h04) begin
				sync_q <= i_wdata[5:0];
			end
			if (i_addr == 8'h44) begin
				mode0_q <= i_wdata[3:0];
			end
		end
	end
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_wr_rd(logic [7:0] a, logic [7:0] b);
		i_wr && i_addr == a ##1 i_rd && i_addr == b;
	endsequence
	property p_rd_idle;
		!i_rd |=> o_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_run_rb;
		s_wr_rd(8'h00, 8'h00) |=> o_rdata[5:0] == $past(i_wdata[5:0], 2);
	endproperty
	a_run_rb: assert property (p_run_rb) else $error("run bits readback");
	property p_sync_rb;
		s_wr_rd(8'h04, 8'h04) |=> o_rdata[5:0] == $past(i_wdata[5:0], 2);
	endproperty
	a_sync_rb: assert property (p_sync_rb) else $error("group bits readback");
	property p_init_lvl;
		i_wr && i_addr == 8'h44 && !run_q[0] |=> o_pin_o[0] == $past(i_wdata[9]) && o_pin_oe[0] == $past(i_wdata[8]);
	endproperty
	a_init_lvl: assert property (p_init_lvl) else $error("initial pin level");
	// settle one cycle after any write, the control write moves the pin
	property p_hold_stop;
		!run_q[0] && !i_wr && !$past(i_wr) |=> $stable(o_pin_o[0]);
	endproperty
	a_hold_stop: assert property (p_hold_stop) else $error("pin moved while halted");
	property p_cnt_rb;
		!run_q[0] ##0 s_wr_rd(8'h40, 8'h40) |=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_cnt_rb: assert property (p_cnt_rb) else $error("counter readback");
	property p_cnt_inc;
		(run_q[0] && mode0_q == 4'h0 && i_rd && i_addr == 8'h40) ##1 (i_rd && i_addr == 8'h40)
			|=> o_rdata == $past(o_rdata) + 16'h0001;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("counter step");
	property p_sync_preset;
		(sync_q[1:0] == 2'h3 && run_q[1:0] == 2'h0) ##0 s_wr_rd(8'h40, 8'h50) |=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_sync_preset: assert property (p_sync_preset) else $error("group preset");
endmodule
bind tcs_timer tcs_chk #(.NCH(NCH)) chk_u (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_pin_o(o_pin_o),
	.o_pin_oe(o_pin_oe)
);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic i_clk, i_rst_n, i_wr, i_rd, o_irq, rd_p;
	logic [7:0] i_addr;
	logic [15:0] i_wdata, o_rdata;
	logic [5:0] o_pin_o, o_pin_oe;
	logic [31:0] exp_q[$]; // expected {value, mask} per read
	logic [31:0] e_w;
	int errors, n_compared;
	// pins and ext clocks idle: capture and ext count left out
	tcs_timer #(.NCH(6)) dut_u (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.i_pin(6'h00),
		.i_ext_clk(6'h00),
		.o_rdata(o_rdata),
		.o_irq(o_irq),
		.o_pin_o(o_pin_o),
		.o_pin_oe(o_pin_oe)
	);
	// ----------
	// bus tasks: each sets every strobe once, then one edge (idle waits n edges)
	// ----------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_wr <= 1'b1;
		i_rd <= 1'b0;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		exp_q.push_back({e, m});
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
	endtask
	task automatic idle(input int n);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		repeat (n) @(posedge i_clk);
	endtask
	task automatic chk16(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
		n_compared++;
		if ((g & m) !== (e & m)) begin
			errors++;
			$display("unexpected %0t: read %h want %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("unexpected %0t: bit %b want %b", $time, g, e);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d n_compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] cbase(input int c);
		return 8'h40 + 8'(c * 16);
	endfunction
	// ----------
	// clock, monitor, watchdog
	// ----------
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		rd_p <= i_rd;
	end
	// read data stand only in the cycle after the strobe
	always @(negedge i_clk) begin
		if (rd_p && exp_q.size() > 0) begin
			e_w = exp_q.pop_front();
			chk16(o_rdata, e_w[31:16], e_w[15:0]);
		end
	end
	initial begin
		repeat (5000) @(posedge i_clk);
		errors++;
		print_verdict();
	end
	// ----------
	// main sequence
	// ----------
	initial begin
		logic [15:0] v;
		int c;
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 16'h0000;
		errors = 0;
		n_compared = 0;
		void'($urandom(14));
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(8'h00, 16'h0000, 16'hFFFF);
		rd(8'h04, 16'h0000, 16'hFFFF);
		rd(8'hFC, 16'h0000, 16'hFFFF);
		// counter, A and C reset values, then random words into A, B and D
		for (c = 0; c < 6; c++) begin
			v = 16'($urandom);
			rd(cbase(c), 16'h0000, 16'hFFFF);
			rd(cbase(c) + 8'h08, 16'hFFFF, 16'hFFFF);
			wr(cbase(c) + 8'h08, v);
			rd(cbase(c) + 8'h08, v, 16'hFFFF);
			wr(cbase(c) + 8'h0C, ~v);
			rd(cbase(c) + 8'h0C, ~v, 16'hFFFF);
			if (c == 0 || c == 3) begin
				rd(8'hC0 + 8'(c * 16), 16'hFFFF, 16'hFFFF);
				wr(8'hC4 + 8'(c * 16), v ^ 16'h5A5A);
				rd(8'hC4 + 8'(c * 16), v ^ 16'h5A5A, 16'hFFFF);
			end
		end
		v = 16'($urandom) & 16'h003F;
		wr(8'h04, v);
		rd(8'h04, v, 16'hFFFF);
		wr(8'h04, 16'h0003);
		v = 16'($urandom);
		wr(8'h40, v);
		rd(8'h50, v, 16'hFFFF);
		rd(8'h60, 16'h0000, 16'hFFFF);
		wr(8'h04, 16'h0000);
		// wrap on ch1, overflow into interrupt
		wr(8'h50, 16'hFFFE);
		wr(8'h00, 16'h0002);
		rd(8'h50, 16'hFFFE, 16'hFFFF);
		rd(8'h50, 16'hFFFF, 16'hFFFF);
		rd(8'h50, 16'h0000, 16'hFFFF);
		rd(8'h08, 16'h0002, 16'h0002);
		wr(8'h0C, 16'h0002);
		idle(3);
		chk1(o_irq, 1'b1);
		wr(8'h0C, 16'h0000);
		idle(3);
		chk1(o_irq, 1'b0);
		wr(8'h0C, 16'h0002);
		wr(8'h08, 16'h0002);
		idle(3);
		chk1(o_irq, 1'b0);
		rd(8'h08, 16'h0000, 16'h0002);
		wr(8'h00, 16'h0000);
		// control write while halted drives the chosen level
		for (c = 0; c < 6; c++) begin
			v = {6'h00, 1'($urandom), 9'h100};
			wr(cbase(c) + 8'h04, v);
			idle(2);
			chk1(o_pin_o[c], v[9]);
			chk1(o_pin_oe[c], 1'b1);
		end
		// toggle on match A, then halt and hold
		wr(8'h44, 16'h0D00);
		wr(8'h48, 16'h0003);
		wr(8'h40, 16'h0000);
		wr(8'h00, 16'h0001);
		rd(8'h40, 16'h0000, 16'hFFFF);
		rd(8'h40, 16'h0001, 16'hFFFF);
		idle(6);
		wr(8'h00, 16'h0000);
		rd(8'h00, 16'h0000, 16'h003F);
		idle(4);
		chk1(o_pin_o[0], 1'b1);
		wr(8'h40, 16'h1234);
		rd(8'h40, 16'h1234, 16'hFFFF);
		rd(8'h40, 16'h1234, 16'hFFFF);
		idle(3);
		print_verdict();
	end
endmodule
